// [adc_readout_params.svh]
// Constants for the converter result readout and status block.
`ifndef ADC_READOUT_PARAMS_SVH
`define ADC_READOUT_PARAMS_SVH

// =============================================================
// Widths and layout
`define RESULT_BITS        14
`define WORD_BITS          16
`define BYTE_BITS          8
`define PAD_BITS           2
`define FIFO_DEPTH         4

// =============================================================
// Timing
`define CLK_PERIOD_NS      100
`define POWERUP_US         10
`define POWERUP_CYCLES     ((`POWERUP_US * 1000) / `CLK_PERIOD_NS)
`define CONVERT_CYCLES     80

`endif

// [adc_readout_pkg.sv]
// Types shared by the converter result readout block.
package adc_readout_pkg;
    typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_CONVERT, ST_DONE} conv_state_e;
    typedef struct packed {
        logic [13:0] code;
        logic        bipolar;
    } sample_s;
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] oe;
    } bus_drive_s;
endpackage : adc_readout_pkg

// [sample_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 4
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_b_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic [WIDTH-1:0]      rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    wire              push = wr_valid_in && wr_ready_out;
    wire              pop  = rd_valid_out && rd_ready_in;

    // Full and empty come straight from the occupancy count.
    assign wr_ready_out = (cnt_q != (AW+1)'(DEPTH));
    assign rd_valid_out = (cnt_q != '0);
    assign rd_data_out  = mem_q[rp_q];

    // =========================================================
    // Storage and pointers.
    always_ff @(posedge ref_clk_in)
    begin
        if (push)
        begin
            mem_q[wp_q] <= wr_data_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wp_q  <= push ? AW'(wp_q + 1'b1) : wp_q;
            rp_q  <= pop ? AW'(rp_q + 1'b1) : rp_q;
            cnt_q <= (AW+1)'(cnt_q + push - pop);
        end
    end
endmodule : sample_fifo

// [adc_result_readout_status.sv]
// Result readout, done status and start control of a 14-bit sampling converter.
`include "adc_readout_params.svh"
`timescale 1ns/1ps
module adc_result_readout_status
    import adc_readout_pkg::*;
#(
    parameter int POWERUP_CYCLES = `POWERUP_CYCLES
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        sync_mode_in,
    input  wire logic        chip_select_n_in,
    input  wire logic        output_enable_n_in,
    input  wire logic        start_conversion_n_in,
    input  wire logic        done_output_enable_n_in,
    input  wire logic        high_byte_select_in,
    input  wire logic        bipolar_offset_pin_in,
    input  wire logic [13:0] core_code_in,
    input  wire logic        core_code_valid_in,
    output logic             core_start_out,
    output logic             converting_out,
    output logic             ready_out,
    output logic [7:0]       result_bus_pins_out,
    output logic [7:0]       result_bus_pins_oe_out,
    output logic             done_pin_out,
    output logic             done_pin_oe_out
);
    // =========================================================
    // Local signals.
    conv_state_e      state_q;
    conv_state_e      state_d;
    logic [15:0]      pwr_cnt_q;
    logic             start_n_q;
    logic [15:0]      word_q;
    logic [7:0]       byte_q;
    logic             bus_en_q;
    logic             done_low_q;
    logic             done_oe_q;
    sample_s          fifo_out;
    logic             fifo_valid;
    logic             fifo_wready;

    // Converts the raw offset-binary core code to the selected coding.
    function automatic logic [15:0] format_word(input sample_s s);
        logic [13:0] c;
        c = s.bipolar ? {~s.code[13], s.code[12:0]} : s.code;
        format_word = {c, 2'b00};
    endfunction : format_word

    // =========================================================
    // Start decode: a falling start edge, qualified by chip select in sync mode.
    wire start_fall = start_n_q && !start_conversion_n_in;
    wire start_ok   = start_fall && (!sync_mode_in || !chip_select_n_in);
    // A start is refused while the FIFO is full so the FIFO never drops a result.
    wire start_go   = start_ok && (state_q == ST_IDLE) && fifo_wready;

    // =========================================================
    // Conversion state machine.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_INIT:    state_d = (pwr_cnt_q == 16'(POWERUP_CYCLES)) ? ST_IDLE : ST_INIT;
            ST_IDLE:    state_d = start_go ? ST_CONVERT : ST_IDLE;
            ST_CONVERT: state_d = core_code_valid_in ? ST_DONE : ST_CONVERT;
            ST_DONE:    state_d = ST_IDLE;
            default:    state_d = ST_INIT;
        endcase
    end

    assign core_start_out = start_go;
    assign converting_out = (state_q == ST_CONVERT) || (state_q == ST_INIT);
    assign ready_out      = (state_q != ST_INIT);

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_q   <= ST_INIT;
            pwr_cnt_q <= 16'h0000;
            start_n_q <= 1'b1;
        end
        else
        begin
            state_q   <= state_d;
            pwr_cnt_q <= (state_q == ST_INIT) ? 16'(pwr_cnt_q + 1'b1) : pwr_cnt_q;
            start_n_q <= start_conversion_n_in;
        end
    end

    // =========================================================
    // Results pass through a FIFO; the output register only takes a new word
    // between reads, so a pair of byte reads within one bus access never straddles two results.
    sample_s fifo_in;
    assign fifo_in.code    = core_code_in;
    assign fifo_in.bipolar = bipolar_offset_pin_in;

    wire bus_access = !chip_select_n_in && !output_enable_n_in;
    wire fifo_take  = fifo_valid && !bus_access;

    sample_fifo #(
        .WIDTH ($bits(sample_s)),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in   (ref_clk_in),
        .rst_b_in     (rst_b_in),
        .wr_data_in   (fifo_in),
        .wr_valid_in  (core_code_valid_in && (state_q == ST_CONVERT)),
        .wr_ready_out (fifo_wready),
        .rd_data_out  (fifo_out),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (fifo_take)
    );

    // Done stays low until the fresh word sits in the output register.
    wire busy = converting_out || (state_q == ST_DONE) || fifo_valid;
    // The accepted start counts as busy already, so done falls on the very next edge
    // rather than one cycle late.
    wire busy_next = busy || start_go;

    // =========================================================
    // Output register and pin drivers.
    wire [7:0] byte_d = high_byte_select_in ? word_q[7:0] : word_q[15:8];

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            word_q     <= 16'h0000;
            byte_q     <= 8'h00;
            bus_en_q   <= 1'b0;
            done_low_q <= 1'b1;
            done_oe_q  <= 1'b0;
        end
        else
        begin
            word_q     <= fifo_take ? format_word(fifo_out) : word_q;
            byte_q     <= byte_d;
            bus_en_q   <= bus_access;
            done_low_q <= busy_next;
            done_oe_q  <= sync_mode_in ? (!chip_select_n_in && !done_output_enable_n_in)
                                       : (busy_next && !done_output_enable_n_in);
        end
    end

    assign result_bus_pins_out    = byte_q;
    assign result_bus_pins_oe_out = {8{bus_en_q}};
    assign done_pin_out           = !done_low_q;
    assign done_pin_oe_out        = done_oe_q;
endmodule : adc_result_readout_status

// [adc_host_bus.sv]
// Host-side wiring model: board pull-up on the done line and the shared data bus.
`timescale 1ns/1ps
module adc_host_bus (
    input  wire logic       ref_clk_in,
    input  wire logic       done_pin_in,
    input  wire logic       done_oe_in,
    input  wire logic [7:0] data_in,
    input  wire logic [7:0] data_oe_in,
    output logic            done_line_out,
    output logic [7:0]      bus_line_out
);
    logic [7:0] last_q;
    // The released done line is pulled high by the board resistor.
    assign done_line_out = done_oe_in ? done_pin_in : 1'b1;
    // A floating bus shows the inverse of its last value, so stale data cannot pass.
    assign bus_line_out = (data_oe_in == 8'hFF) ? data_in : ~last_q;
    // Remember the last bus value.
    always_ff @(posedge ref_clk_in) last_q <= bus_line_out;
endmodule : adc_host_bus

// [adc_result_readout_status_properties.sv]
// Concurrent checks on the ports of the readout and done status block.
`timescale 1ns/1ps
module adc_readout_checker (
    input wire logic       ref_clk_in,
    input wire logic       rst_b_in,
    input wire logic       sync_mode_in,
    input wire logic       chip_select_n_in,
    input wire logic       output_enable_n_in,
    input wire logic       done_output_enable_n_in,
    input wire logic       core_code_valid_in,
    input wire logic       core_start_out,
    input wire logic       converting_out,
    input wire logic [7:0] result_bus_pins_oe_out,
    input wire logic       done_pin_out,
    input wire logic       done_pin_oe_out
);
    // ==============================================================
    // Bus and done pin relations
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    property p_bus_on;
        !chip_select_n_in && !output_enable_n_in |=> result_bus_pins_oe_out == 8'hFF;
    endproperty
    a_bus_on: assert property (p_bus_on) else $error("bus not driven");
    property p_bus_off;
        chip_select_n_in || output_enable_n_in |=> result_bus_pins_oe_out == 8'h00;
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus not floated");
    property p_sync_on;
        sync_mode_in && !chip_select_n_in && !done_output_enable_n_in |=> done_pin_oe_out;
    endproperty
    a_sync_on: assert property (p_sync_on) else $error("done not driven");
    property p_sync_off;
        sync_mode_in && (chip_select_n_in || done_output_enable_n_in) |=> !done_pin_oe_out;
    endproperty
    a_sync_off: assert property (p_sync_off) else $error("done not floated");
    property p_drain;
        !sync_mode_in && $stable(sync_mode_in) && done_pin_oe_out |-> !done_pin_out;
    endproperty
    a_drain: assert property (p_drain) else $error("open drain drove high");
    property p_drain_off;
        !sync_mode_in && done_output_enable_n_in |=> !done_pin_oe_out;
    endproperty
    a_drain_off: assert property (p_drain_off) else $error("done not released");
    property p_busy;
        core_start_out |=> (!done_pin_out) [*8];
    endproperty
    a_busy: assert property (p_busy) else $error("done high while busy");
    property p_finish;
        converting_out && core_code_valid_in |-> ##[1:8] done_pin_out;
    endproperty
    a_finish: assert property (p_finish) else $error("done did not rise");
endmodule : adc_readout_checker
bind adc_result_readout_status adc_readout_checker chk (.*);

// [tb_adc_result_readout_status.sv]
// Self-checking bench for the result readout and done status block.
`timescale 1ns/1ps
module tb_adc_result_readout_status;
    logic        ref_clk_in, rst_b_in, sync_mode, cs_n, oe_n, sc_n, den_n, hbs, bip, cv;
    logic [13:0] code;
    logic [7:0]  bus, bus_oe, bus_line;
    logic        done, done_oe, done_line, start, conv, rdy;
    logic [15:0] w;
    logic [31:0] seed = 32'h5AD7E8B8;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          k;
    // ==============================================================
    // Design, host wiring and clock
    adc_result_readout_status #(.POWERUP_CYCLES(4)) DUT (.ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in), .sync_mode_in(sync_mode), .chip_select_n_in(cs_n),
        .output_enable_n_in(oe_n), .start_conversion_n_in(sc_n),
        .done_output_enable_n_in(den_n), .high_byte_select_in(hbs),
        .bipolar_offset_pin_in(bip), .core_code_in(code), .core_code_valid_in(cv),
        .core_start_out(start), .converting_out(conv), .ready_out(rdy),
        .result_bus_pins_out(bus), .result_bus_pins_oe_out(bus_oe),
        .done_pin_out(done), .done_pin_oe_out(done_oe));
    adc_host_bus host (.ref_clk_in(ref_clk_in), .done_pin_in(done), .done_oe_in(done_oe),
        .data_in(bus), .data_oe_in(bus_oe), .done_line_out(done_line), .bus_line_out(bus_line));
    // Free-running 10 MHz clock.
    initial
    begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    // ==============================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // Bipolar flips the top bit of the offset-binary code; two pad zeros follow.
    function automatic logic [15:0] exp_word(input logic [13:0] c, input logic b);
        return {b ^ c[13], c[12:0], 2'h0};
    endfunction : exp_word
    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        samples_checked++;
        if (seen !== expv)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask : check
    // Inputs always change 10 ns after the rising edge.
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_in);
        #10;
    endtask : step
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    // ==============================================================
    // Main sequence: conversions in both modes with corner codes, then two-byte reads.
    initial
    begin
        {rst_b_in, sync_mode, cs_n, oe_n, sc_n, den_n, hbs, bip, cv} = 9'h070;
        code = 14'h0000;
        step(12);
        rst_b_in = 1'b1;
        #1 check({15'h0000, rdy}, 16'h0000);
        for (k = 0; k < 50 && !rdy; k++) step(1);
        if (!rdy)
        begin
            n_fail++;
            tally_and_finish();
        end
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            sync_mode = (i < 2) ? i[0] : seed[0];
            code = (i == 0) ? 14'h3FFF : (i == 1) ? 14'h0000 : seed[14:1];
            bip = seed[15];
            cs_n = ~sync_mode;
            step(1);
            sc_n = 1'b0;
            #1 check({15'h0000, start}, 16'h0001);
            step(1);
            sc_n = 1'b1;
            den_n = seed[16];
            step(3);
            check({15'h0000, done_line}, {15'h0000, den_n});
            check({15'h0000, conv}, 16'h0001);
            den_n = 1'b0;
            sc_n = 1'b0;
            #1 check({15'h0000, start}, 16'h0000);
            step(1);
            sc_n = 1'b1;
            step(5);
            cv = 1'b1;
            step(1);
            cv = 1'b0;
            for (k = 0; k < 20 && done_line !== 1'b1; k++) step(1);
            check({15'h0000, done_line}, 16'h0001);
            w = exp_word(code, bip);
            {cs_n, oe_n, hbs} = 3'h0;
            step(2);
            check({8'h00, bus_line}, {8'h00, w[15:8]});
            hbs = 1'b1;
            step(2);
            check({8'h00, bus_line}, {8'h00, w[7:0]});
            {cs_n, oe_n} = 2'h3;
            step(2);
            check({8'h00, bus_oe}, 16'h0000);
        end
        tally_and_finish();
    end
endmodule : tb_adc_result_readout_status
